// File: pioc_port_io.sv
// Port I/O configuration block: five 8-bit ports with config, data and pin registers.
// Assumes pin levels arrive asynchronously and a board resolves each pad from out/oe/pullup.
// Behaviour
// (RULE_01) Config/data select hi-Z, pull-up, or push-pull
// (RULE_02) Each port has config, data, pin registers
// (RULE_03) Every bit configured independently
// (RULE_04) Software masks unbonded port A bits
// (RULE_05) Port G bit 6 always hi-Z input
// (RULE_06) Watchdog option makes bit 1 pulled-up output
// (RULE_07) Bit 1 config/data ignored under watchdog
// (RULE_08) Port G bit 7 always clock output
// (RULE_09) G data bits 6,7 read zero
// (RULE_10) Writing G data bit7 enters HALT
// (RULE_11) Writing G data bit6 enters IDLE
// (RULE_12) G config bit6 selects alternate clock phase
// (RULE_13) G config bit7 enables RC restart delay
// (RULE_14) HALT stops oscillator until wake
// (RULE_15) Port G alternate functions routed
// (RULE_16) All port L pins wake sources
// (RULE_17) Port L alternate functions routed
// (RULE_18) G0-G3 reachable by emulator unchanged; G1 is taken over for the watchdog when that option is selected
// (RULE_19) Pin register returns synchronized levels
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none

module pioc_port_io
  import pioc_pkg::*;
(
  input  wire logic        clk,               // Core clock, 200 MHz
  input  wire logic        sys_rst,           // Synchronous reset, active high
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,      // Write address
  input  wire logic        s_axi_awvalid,     // Write address valid
  output logic             s_axi_awready,     // Write address ready
  input  wire logic [31:0] s_axi_wdata,       // Write data
  input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
  input  wire logic        s_axi_wvalid,      // Write data valid
  output logic             s_axi_wready,      // Write data ready
  output logic [1:0]       s_axi_bresp,       // Write response
  output logic             s_axi_bvalid,      // Write response valid
  input  wire logic        s_axi_bready,      // Write response ready
  input  wire logic [7:0]  s_axi_araddr,      // Read address
  input  wire logic        s_axi_arvalid,     // Read address valid
  output logic             s_axi_arready,     // Read address ready
  output logic [31:0]      s_axi_rdata,       // Read data
  output logic [1:0]       s_axi_rresp,       // Read response
  output logic             s_axi_rvalid,      // Read data valid
  input  wire logic        s_axi_rready,      // Read data ready
  // Pads, five ports of eight, flattened port-major
  input  wire logic [39:0] pad_in,            // Pad levels, asynchronous
  output logic [39:0]      pad_out,           // Pad output value
  output logic [39:0]      pad_oe,            // Pad output enable, high drives
  output logic [39:0]      pad_pullup,        // Weak pull-up enable
  // Peripheral hookups
  input  wire logic        osc_clock_input,   // Oscillator clock, sampled as data
  input  wire logic        watchdog_level,    // Watchdog/clock monitor output level
  input  wire logic        wake_event,        // Any wake source, leaves halt/idle
  input  wire logic        serial_data_out,   // Serial data out to G4
  output logic             serial_data_in,    // Synchronised port G bit 6
  output logic             serial_shift_clock,// Synchronised G5
  output logic             serial_alt_phase,  // Alternate shift phase
  output logic             timer1_io_pin,     // Synchronised G3
  output logic             timer1_capture_pin,// Synchronised G2
  output logic             external_irq_pin,  // Synchronised G0
  output logic             timer2_input_a,    // Synchronised L4
  output logic             timer2_input_b,    // Synchronised L5
  output logic             uart_receive_pin,  // Synchronised L3
  output logic             uart_clock_pin,    // Synchronised L1
  output logic [7:0]       portl_wake,        // Port L wake sources
  output logic             halt_mode,         // Halt active
  output logic             idle_mode,         // Idle active
  output logic             osc_stop,          // Oscillator stop request
  output logic             halt_restart_delay_en // Restart delay armed
);

  // Register storage
  logic [NPORT-1:0][PW-1:0] cfg_q;            // port_direction_config per port
  logic [NPORT-1:0][PW-1:0] dat_q;            // port_output_value per port
  logic [NPORT-1:0][PW-1:0] sync1_q;          // First synchroniser stage
  logic [NPORT-1:0][PW-1:0] pin_q;            // port_pin_level, second stage
  logic [31:0]              ctrl_q;           // Option word
  logic                     halt_q;           // Halt state
  logic                     idle_q;           // Idle state
  logic                     osc1_q;           // Oscillator sync stage 1
  logic                     osc_q;            // Oscillator sync stage 2

  // Write channel state
  logic        aw_have_q;                     // Address captured
  logic        w_have_q;                      // Data captured
  logic [7:0]  aw_addr_q;                     // Captured address
  logic [31:0] w_data_q;                      // Captured data
  logic [3:0]  w_strb_q;                      // Captured strobes
  logic        wr_fire;                       // Both halves in hand

  // Decode: returns port index or NPORT for non-port address
  function automatic logic [2:0] port_of(input logic [7:0] a);
    logic [3:0] slot;
    slot = a[7:SLOT_LSB];
    if (slot < 4'(NPORT) && a[1:0] == 2'b00 && a[3:2] != 2'b11)
      port_of = slot[2:0];
    else
      port_of = 3'(NPORT);
  endfunction

  // Offset within a port slot
  function automatic logic [7:0] sub_of(input logic [7:0] a);
    sub_of = {4'h0, a[3:0]};
  endfunction

  // Write handshake: accept address and data in either order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (port_of(aw_addr_q) != 3'(NPORT) || aw_addr_q == OFS_CTRL)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries port data
  // (RULE_02) Config and data storage
  // (RULE_03) Whole-byte independent bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= '0;
      dat_q <= '0;
    end else if (wr_fire && w_strb_q[0] && port_of(aw_addr_q) != 3'(NPORT)) begin
      if (sub_of(aw_addr_q) == OFS_CFG)
        cfg_q[port_of(aw_addr_q)] <= w_data_q[7:0];
      else if (sub_of(aw_addr_q) == OFS_DATA)
        dat_q[port_of(aw_addr_q)] <= w_data_q[7:0];
    end
  end

  // Option word, low byte writable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= RST_CTRL;
    end else if (wr_fire && w_strb_q[0] && aw_addr_q == OFS_CTRL) begin
      ctrl_q <= {24'h00_0000, w_data_q[7:0]};
    end
  end

  // Power mode entry and wake
  // (RULE_10) Halt on G data bit7
  // (RULE_11) Idle on G data bit6
  // (RULE_14) Halt held until wake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      halt_q <= 1'b0;
      idle_q <= 1'b0;
    end else if (wr_fire && w_strb_q[0] && port_of(aw_addr_q) == PORT_G
                 && sub_of(aw_addr_q) == OFS_DATA) begin
      // A new write wins over a coincident wake so the request is not lost
      halt_q <= w_data_q[G_CLKO] | (halt_q & ~wake_event);
      idle_q <= w_data_q[G_IN6]  | (idle_q & ~wake_event);
    end else if (wake_event) begin
      halt_q <= 1'b0;
      idle_q <= 1'b0;
    end
  end

  // Pad input synchronisers, two stages each
  // (RULE_19) Synchronised pin levels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      pin_q   <= '0;
      osc1_q  <= 1'b0;
      osc_q   <= 1'b0;
    end else begin
      sync1_q <= pad_in;
      pin_q   <= sync1_q;
      osc1_q  <= osc_clock_input;
      osc_q   <= osc1_q;
    end
  end

  // Read channel; single-cycle decode, rvalid held until rready
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == OFS_CTRL) begin
          s_axi_rdata              <= ctrl_q;
          s_axi_rdata[CTRL_HALT]   <= halt_q;
          s_axi_rdata[CTRL_IDLE]   <= idle_q;
        end else if (port_of(s_axi_araddr) == 3'(NPORT)) begin
          s_axi_rresp <= RESP_SLVERR;
        end else if (sub_of(s_axi_araddr) == OFS_CFG) begin
          s_axi_rdata[7:0] <= cfg_q[port_of(s_axi_araddr)];
        end else if (sub_of(s_axi_araddr) == OFS_DATA) begin
          s_axi_rdata[7:0] <= dat_q[port_of(s_axi_araddr)];
          // (RULE_09) Port G data bits 7:6 read zero
          if (port_of(s_axi_araddr) == PORT_G)
            s_axi_rdata[7:6] <= 2'b00;
        end else begin
          // (RULE_04) Port A raw levels returned
          s_axi_rdata[7:0] <= pin_q[port_of(s_axi_araddr)];
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pad drivers, one generate slice per port bit
  // (RULE_01) Mode table per bit
  // (RULE_18) G0, G2, G3 keep ordinary pad behaviour; G1 does too unless the watchdog option is selected
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    for (genvar b = 0; b < PW; b++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pad_out[p*PW+b]    <= 1'b0;
          pad_oe[p*PW+b]     <= 1'b0;
          pad_pullup[p*PW+b] <= 1'b0;
        end else if (p == int'(PORT_G) && b == G_IN6) begin
          // (RULE_05) Bit 6 fixed hi-Z input
          pad_out[p*PW+b]    <= 1'b0;
          pad_oe[p*PW+b]     <= 1'b0;
          pad_pullup[p*PW+b] <= 1'b0;
        end else if (p == int'(PORT_G) && b == G_CLKO) begin
          // (RULE_08) Bit 7 drives clock out
          pad_out[p*PW+b]    <= osc_q;
          pad_oe[p*PW+b]     <= 1'b1;
          pad_pullup[p*PW+b] <= 1'b0;
        end else if (p == int'(PORT_G) && b == G_WDOG && ctrl_q[CTRL_WDOG_EN]) begin
          // (RULE_06) Watchdog pin, pulled up
          // (RULE_07) Config/data ignored here
          pad_out[p*PW+b]    <= 1'b0;
          pad_oe[p*PW+b]     <= ~watchdog_level;
          pad_pullup[p*PW+b] <= 1'b1;
        end else if (p == int'(PORT_G) && b == G_SO && cfg_q[p][b]) begin
          // (RULE_15) Serial out on G4 when output
          pad_out[p*PW+b]    <= serial_data_out & dat_q[p][b];
          pad_oe[p*PW+b]     <= 1'b1;
          pad_pullup[p*PW+b] <= 1'b0;
        end else begin
          pad_out[p*PW+b]    <= cfg_q[p][b] & dat_q[p][b];
          pad_oe[p*PW+b]     <= cfg_q[p][b];
          pad_pullup[p*PW+b] <= ~cfg_q[p][b] & dat_q[p][b];
        end
      end
    end
  end

  // Alternate input functions taken from synchronised levels
  // (RULE_15) Port G alternates
  // (RULE_16) Port L wake sources
  // (RULE_17) Port L alternates
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_data_in     <= 1'b0;
      serial_shift_clock <= 1'b0;
      timer1_io_pin      <= 1'b0;
      timer1_capture_pin <= 1'b0;
      external_irq_pin   <= 1'b0;
      timer2_input_a     <= 1'b0;
      timer2_input_b     <= 1'b0;
      uart_receive_pin   <= 1'b0;
      uart_clock_pin     <= 1'b0;
      portl_wake         <= 8'h00;
    end else begin
      serial_data_in     <= pin_q[PORT_G][G_IN6];
      serial_shift_clock <= pin_q[PORT_G][G_SCLK];
      timer1_io_pin      <= pin_q[PORT_G][G_T1IO];
      timer1_capture_pin <= pin_q[PORT_G][G_T1CAP];
      external_irq_pin   <= pin_q[PORT_G][G_IRQ];
      timer2_input_a     <= pin_q[PORT_L][4];
      timer2_input_b     <= pin_q[PORT_L][5];
      uart_receive_pin   <= pin_q[PORT_L][3];
      uart_clock_pin     <= pin_q[PORT_L][1];
      portl_wake         <= pin_q[PORT_L];
    end
  end

  // Special controls from port G upper config bits, plus registered halt, idle and oscillator-stop outputs
  // (RULE_12) Alternate shift phase
  // (RULE_13) Restart delay only with RC clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_alt_phase      <= 1'b0;
      halt_restart_delay_en <= 1'b0;
      halt_mode             <= 1'b0;
      idle_mode             <= 1'b0;
      osc_stop              <= 1'b0;
    end else begin
      serial_alt_phase      <= cfg_q[PORT_G][G_IN6];
      halt_restart_delay_en <= cfg_q[PORT_G][G_CLKO] & ctrl_q[CTRL_RC_CLK];
      halt_mode             <= halt_q;
      idle_mode             <= idle_q;
      // (RULE_14) Oscillator stopped in halt
      osc_stop              <= halt_q;
    end
  end

endmodule

`default_nettype wire

// File: pioc_pkg.sv
// Package for the port configuration block: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package pioc_pkg;

  // Port count and width
  localparam int unsigned NPORT = 5;                 // Ports A, B, G, H, L
  localparam int unsigned PW    = 8;                 // Bits per port

  // Port indices
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_G = 3'h2;
  localparam logic [2:0] PORT_H = 3'h3;
  localparam logic [2:0] PORT_L = 3'h4;

  // Register map: each port owns a 16-byte slot, three words used
  localparam logic [7:0] OFS_CFG   = 8'h00;          // port_direction_config
  localparam logic [7:0] OFS_DATA  = 8'h04;          // port_output_value
  localparam logic [7:0] OFS_PIN   = 8'h08;          // port_pin_level
  localparam logic [7:0] OFS_CTRL  = 8'h50;          // Option and status word
  localparam int unsigned SLOT_LSB = 4;              // Address bit of the port index

  // Control word fields
  localparam int unsigned CTRL_WDOG_EN = 0;          // Watchdog selected on port G bit 1 (RW)
  localparam int unsigned CTRL_RC_CLK  = 1;          // RC clock configuration (RW)
  localparam int unsigned CTRL_HALT    = 8;          // Halt state (RO)
  localparam int unsigned CTRL_IDLE    = 9;          // Idle state (RO)

  // Port G special bit positions
  localparam int unsigned G_IRQ   = 0;
  localparam int unsigned G_WDOG  = 1;
  localparam int unsigned G_T1CAP = 2;
  localparam int unsigned G_T1IO  = 3;
  localparam int unsigned G_SO    = 4;
  localparam int unsigned G_SCLK  = 5;
  localparam int unsigned G_IN6   = 6;
  localparam int unsigned G_CLKO  = 7;

  // Reset values
  localparam logic [7:0]  RST_PORT = 8'h00;          // All pins Hi-Z input except G7 clock output
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: pioc_port_io_checker.sv
// Assertion checker for the port configuration block, bound to its top module.
// Assumes the bus master offers write address and data in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module pioc_port_io_checker
  import pioc_pkg::*;
(
  input wire logic        clk,              // Core clock
  input wire logic        sys_rst,          // Sync reset
  input wire logic [7:0]  s_axi_awaddr,     // Write address
  input wire logic        s_axi_awvalid,    // AW valid
  input wire logic        s_axi_awready,    // AW ready
  input wire logic [31:0] s_axi_wdata,      // Write data
  input wire logic [3:0]  s_axi_wstrb,      // Strobes
  input wire logic        s_axi_wvalid,     // W valid
  input wire logic        s_axi_wready,     // W ready
  input wire logic [7:0]  s_axi_araddr,     // Read address
  input wire logic        s_axi_arvalid,    // AR valid
  input wire logic        s_axi_arready,    // AR ready
  input wire logic [31:0] s_axi_rdata,      // Read data
  input wire logic [1:0]  s_axi_rresp,      // Read response
  input wire logic        s_axi_rvalid,     // R valid
  input wire logic [39:0] pad_in,           // Pad levels
  input wire logic [39:0] pad_out,          // Pad value
  input wire logic [39:0] pad_oe,           // Pad enable
  input wire logic [39:0] pad_pullup,       // Pad pull-up
  input wire logic        osc_clock_input,  // Oscillator
  input wire logic        wake_event,       // Wake
  input wire logic        external_irq_pin, // G0 input
  input wire logic        uart_receive_pin, // L3 input
  input wire logic [7:0]  portl_wake,       // Wake sources
  input wire logic        halt_mode,        // Halt
  input wire logic        idle_mode,        // Idle
  input wire logic        osc_stop          // Oscillator stop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] ar_q; // Address of the read under way
  logic       gwr;  // Port G data write taken whole this cycle
  // Keep the read address so the answer can be judged
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  assign gwr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == 8'h24 && s_axi_wstrb[0];

  pull_drive_excl_a: assert property ((pad_oe & pad_pullup & ~40'h00_0002_0000) == 40'h0)
    else $error("pull-up on a driven pad");
  g6_hiz_in_a: assert property (!pad_oe[22] && !pad_pullup[22])
    else $error("port G bit 6 not a plain input");
  g7_clk_en_a: assert property (!sys_rst |=> pad_oe[23])
    else $error("clock output pad not driven");
  g7_clk_follow_a: assert property (($stable(osc_clock_input))[*5] |-> pad_out[23] == osc_clock_input)
    else $error("clock output pad does not follow oscillator");
  g_data_zero_a: assert property (s_axi_rvalid && ar_q == 8'h24 |-> s_axi_rdata[7:6] == 2'b00)
    else $error("G data bits 7:6 read nonzero");
  halt_entry_a: assert property (gwr && s_axi_wdata[7] |-> ##[1:4] (halt_mode && osc_stop))
    else $error("halt not entered");
  idle_entry_a: assert property (gwr && s_axi_wdata[6] |-> ##[1:4] idle_mode)
    else $error("idle not entered");
  halt_holds_a: assert property (halt_mode && !wake_event && !$past(wake_event) |=> halt_mode)
    else $error("halt left without wake");
  wake_follow_a: assert property (($stable(pad_in[39:32]))[*4] |-> portl_wake == pad_in[39:32])
    else $error("wake sources differ from port L");
  alt_follow_a: assert property (($stable(pad_in[16]) && $stable(pad_in[35]))[*4] |-> external_irq_pin == pad_in[16] && uart_receive_pin == pad_in[35])
    else $error("alternate input differs from pad");
  unmapped_err_a: assert property (s_axi_rvalid && ar_q > OFS_CTRL |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule

bind pioc_port_io pioc_port_io_checker chk_u (.*);
`default_nettype wire

// File: pioc_pad_board.sv
// Board model on the pads: resolves each pad level and runs the oscillator.
// Assumes the bench drives only pads that the block leaves undriven.
`timescale 1ns/10ps
`default_nettype none

module pioc_pad_board (
  input  wire logic        clk,            // Core clock
  input  wire logic [39:0] pad_out,        // Block drive value
  input  wire logic [39:0] pad_oe,         // Block drive enable
  input  wire logic [39:0] pad_pullup,     // Block weak pull-up
  input  wire logic [39:0] ext_en,         // Board drives pad
  input  wire logic [39:0] ext_val,        // Board drive value
  input  wire logic        osc_stop,       // Oscillator stop request
  output logic [39:0]      pad_in,         // Resolved pad levels
  output logic             osc_clock_input // Oscillator level
);
  logic [39:0] flt_q = 40'h55_5555_5555; // Open pads flip, so no stale level looks real
  logic [3:0]  div_q = 4'h0;             // Oscillator divider
  // Open pad pattern
  always_ff @(posedge clk) flt_q <= ~flt_q;
  always_ff @(posedge clk) begin
    if (!osc_stop) begin
      div_q <= div_q + 4'h1;
    end
  end
  assign osc_clock_input = div_q[3];
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | flt_q));
endmodule
`default_nettype wire

// File: pioc_port_io_tb_top.sv
// Testbench top for the port configuration block: AXI4-Lite master and scenarios.
// Assumes the board model sits on the pads and supplies the oscillator.
`timescale 1ns/10ps
`default_nettype none

module pioc_port_io_tb_top
  import pioc_pkg::*;
;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        watchdog_level = 1'b0, wake_event = 1'b0, serial_data_out = 1'b0;
  logic [39:0] ext_en = 40'h00_0000_0000, ext_val = 40'h00_0000_0000;
  logic [39:0] pad_in, pad_out, pad_oe, pad_pullup;
  logic        osc_clock_input, osc_stop, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, serial_data_in, serial_shift_clock;
  logic        serial_alt_phase, timer1_io_pin, timer1_capture_pin, external_irq_pin;
  logic        timer2_input_a, timer2_input_b, uart_receive_pin, uart_clock_pin;
  logic        halt_mode, idle_mode, halt_restart_delay_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  portl_wake, v;
  int          n_errors = 0, n_tests = 0;

  pioc_port_io   dut_u (.*);
  pioc_pad_board brd_u (.*);

  // 200 MHz core clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cut a hang short, far beyond the few hundred cycles the run needs
  initial begin
    #50_000;
    n_errors++;
    wrap_up();
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [7:0] ra(input logic [2:0] p, input logic [7:0] o);
    return {1'b0, p, 4'h0} | o;
  endfunction

  // One write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ga = 1'b0;
    logic gw = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      ga = ga | (s_axi_awready === 1'b1);
      gw = gw | (s_axi_wready === 1'b1);
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Write expecting OKAY, then let outputs settle
  task automatic w8(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rs;
    wr(a, d, rs);
    chk(rs, RESP_OKAY);
    tick(2);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(a, d, rs);
    chk(d, e);
    chk(rs, RESP_OKAY);
  endtask

  // Reset values, pads idle, unmapped place refused
  task automatic s_reset();
    logic [31:0] d;
    logic [1:0]  rs;
    for (int p = 0; p < NPORT; p++) begin
      rc(ra(3'(p), OFS_CFG), {24'h0, RST_PORT});
      rc(ra(3'(p), OFS_DATA), {24'h0, RST_PORT});
    end
    rc(OFS_CTRL, RST_CTRL);
    chk(pad_oe, 40'h00_0080_0000);
    chk(pad_pullup, 40'h00_0000_0000);
    rd(8'h5C, d, rs);
    chk({rs, d}, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h5C, 32'h0000_00FF, rs);
    chk(rs, RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    w8(ra(PORT_A, OFS_CFG), 32'h0000_00FF);
    s_axi_wstrb <= 4'hF;
    rc(ra(PORT_A, OFS_CFG), {24'h0, RST_PORT});
  endtask

  // All four set-ups in one write per register, every plain port
  task automatic s_modes();
    for (int i = 0; i < NPORT; i++) begin
      if (3'(i) != PORT_G) begin
        w8(ra(3'(i), OFS_CFG), 32'h0000_00F0);
        w8(ra(3'(i), OFS_DATA), 32'h0000_00CC);
        rc(ra(3'(i), OFS_CFG), 32'h0000_00F0);
        chk(pad_oe[i*8 +: 8], 8'hF0);
        chk(pad_out[i*8 +: 8] & 8'hF0, 8'hC0);
        chk(pad_pullup[i*8 +: 8], 8'h0C);
      end
    end
  endtask

  // Pin levels; port A bits 1:0 treated as unbonded and masked
  task automatic s_pins();
    logic [31:0] d;
    logic [1:0]  rs;
    ext_en[9:8]  <= 2'b11;
    ext_val[9:8] <= 2'b01;
    tick(4);
    rc(ra(PORT_B, OFS_PIN), 32'h0000_00CD);
    rd(ra(PORT_A, OFS_PIN), d, rs);
    chk(d & 32'h0000_00FC, 32'h0000_00CC);
  endtask

  // Port G special bits and the watchdog pin
  task automatic s_portg();
    watchdog_level <= 1'b1;
    w8(ra(PORT_G, OFS_CFG), 32'h0000_007F);
    w8(ra(PORT_G, OFS_DATA), 32'h0000_003F);
    rc(ra(PORT_G, OFS_DATA), 32'h0000_003F);
    chk(serial_alt_phase, 1'b1);
    chk({pad_oe[22], pad_oe[17], pad_out[17]}, 3'b011);
    w8(OFS_CTRL, 32'h0000_0001);
    chk({pad_oe[17], pad_pullup[17]}, 2'b01);
    watchdog_level <= 1'b0;
    w8(ra(PORT_G, OFS_CFG), 32'h0000_007D);
    w8(ra(PORT_G, OFS_DATA), 32'h0000_003D);
    chk({pad_oe[17], pad_pullup[17]}, 2'b11);
    w8(OFS_CTRL, 32'h0000_0000);
    chk({pad_oe[17], pad_pullup[17]}, 2'b00);
  endtask

  // Restart delay, idle and halt entry and wake
  task automatic s_halt();
    w8(OFS_CTRL, 32'h0000_0002);
    w8(ra(PORT_G, OFS_CFG), 32'h0000_0080);
    chk(halt_restart_delay_en, 1'b1);
    w8(OFS_CTRL, 32'h0000_0000);
    chk(halt_restart_delay_en, 1'b0);
    w8(ra(PORT_G, OFS_DATA), 32'h0000_0040);
    chk({idle_mode, halt_mode}, 2'b10);
    rc(OFS_CTRL, 32'h0000_0200);
    wake_event <= 1'b1;
    tick(1);
    wake_event <= 1'b0;
    tick(3);
    chk(idle_mode, 1'b0);
    w8(ra(PORT_G, OFS_DATA), 32'h0000_0080);
    tick(20);
    chk({halt_mode, osc_stop}, 2'b11);
    rc(ra(PORT_G, OFS_DATA), 32'h0000_0000);
    wake_event <= 1'b1;
    tick(1);
    wake_event <= 1'b0;
    tick(3);
    chk({halt_mode, osc_stop}, 2'b00);
  endtask

  // Alternate inputs, wake sources and serial data out on G4
  task automatic s_alt();
    w8(ra(PORT_L, OFS_CFG), 32'h0000_0000);
    w8(ra(PORT_L, OFS_DATA), 32'h0000_0000);
    w8(ra(PORT_G, OFS_CFG), 32'h0000_0090);
    w8(ra(PORT_G, OFS_DATA), 32'h0000_0010);
    ext_en <= 40'hFF_006D_0000;
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h5A : 8'hA5;
      ext_val <= {v, 8'h00, ~v, 16'h0000};
      serial_data_out <= v[0];
      tick(5);
      chk(portl_wake, v);
      chk({timer2_input_b, timer2_input_a, uart_receive_pin, uart_clock_pin}, {v[5:3], v[1]});
      chk({serial_data_in, serial_shift_clock, timer1_io_pin}, {~v[6], ~v[5], ~v[3]});
      chk({timer1_capture_pin, external_irq_pin, pad_out[20]}, {~v[2], ~v[0], v[0]});
    end
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    s_reset();
    s_modes();
    s_pins();
    s_portg();
    s_halt();
    s_alt();
    wrap_up();
  end
endmodule
`default_nettype wire
